// >>> hw/wake_pkg.sv
// shared constants and types for the wake-on-wireless handshake
package wake_pkg;

  // host link kinds, as presented on the link-type input
  typedef enum logic [2:0] {
    LINK_UART    = 3'b000,
    LINK_SDIO    = 3'b001,
    LINK_SPI     = 3'b010,
    LINK_USB     = 3'b011,
    LINK_USB_CDC = 3'b100
  } host_link_e;

  // handshake states
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_WAIT_ACK = 2'b01,
    ST_XFER     = 2'b10,
    ST_NP_WAIT  = 2'b11
  } wake_state_e;

  // feature flag widths and bit positions
  localparam int unsigned FLAGS_W          = 32;
  localparam int unsigned ACTIVE_HIGH_BIT  = 16;
  localparam int unsigned ACK_POLL_BIT     = 11;

  // values after reset
  localparam logic        RST_ACTIVE_HIGH  = 1'b0;
  localparam logic        RST_POLL_EN      = 1'b0;
  localparam logic        RST_WAKE_PIN     = 1'b1;
  localparam logic        RST_SYNC_STAGE   = 1'b0;

  // synchroniser depth in cycles
  localparam int unsigned SYNC_STAGES      = 2;

endpackage

// >>> hw/wake_level_sync.sv
// two-flop synchroniser for one level arriving from the host clock domain
`timescale 1ns/100ps
module wake_level_sync (
  // clock and reset
  input  wire logic CLK_SYS,
  input  wire logic RST_N,
  // level in and out
  input  wire logic async_in,
  output logic      sync_out
);
  import wake_pkg::*;

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_s;

  sync_s cur;
  sync_s next_cur;

  // first stage feeds only the second stage
  always_comb begin
    next_cur.meta   = async_in;
    next_cur.stable = cur.meta;
  end

  // synchronous reset to constants only
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cur.meta   <= RST_SYNC_STAGE;
      cur.stable <= RST_SYNC_STAGE;
    end else begin
      cur <= next_cur;
    end
  end

  assign sync_out = cur.stable;

endmodule

// >>> hw/wake_on_wireless_handshake.sv
// wake-on-wireless handshake: device side of the wake request / ack pin pair
`timescale 1ns/100ps
module wake_on_wireless_handshake (
  // clock and reset
  input  wire logic                            CLK_SYS,
  input  wire logic                            RST_N,
  // operating-mode setup
  input  wire logic                            MODE_SETUP,
  input  wire logic [wake_pkg::FLAGS_W-1:0]    CONFIG_FEATURE_FLAGS,
  input  wire logic [wake_pkg::FLAGS_W-1:0]    CUSTOM_FEATURE_FLAGS,
  input  wire wake_pkg::host_link_e            HOST_LINK,
  // packet side
  input  wire logic                            PKT_PENDING,
  input  wire logic                            PKT_DONE,
  output logic                                 XFER_GO,
  output logic                                 WAKE_BUSY,
  output logic                                 ACTIVE_HIGH,
  output logic                                 ACK_POLL_EN,
  // handshake pins
  output logic                                 DEVICE_WAKE_REQUEST,
  input  wire logic                            HOST_WAKE_ACK
);
  import wake_pkg::*;

  typedef struct packed {
    wake_state_e state;
    logic        active_high;
    logic        poll_en;
    logic        wake_pin;
    logic        xfer_go;
  } wake_s;

  wake_s cur;
  wake_s next_cur;
  logic  ack_s;

  // level the request pin rests at when nothing is pending
  function automatic logic idle_level(input logic poll, input logic hi);
    // non-polling scheme always rests high, polling rests opposite to active
    idle_level = poll ? ~hi : 1'b1;
  endfunction

  // ack comes from an unrelated host clock, so it is synchronised first
  wake_level_sync u_ack_sync (
    .CLK_SYS  (CLK_SYS),
    .RST_N    (RST_N),
    .async_in (HOST_WAKE_ACK),
    .sync_out (ack_s)
  );

  // handshake sequencing
  always_comb begin
    next_cur         = cur;
    next_cur.xfer_go = 1'b0;
    case (cur.state)
      ST_IDLE: begin
        if (MODE_SETUP) begin
          // config only changes between packets, never mid-handshake
          next_cur.active_high = CONFIG_FEATURE_FLAGS[ACTIVE_HIGH_BIT];
          next_cur.poll_en     = (HOST_LINK == LINK_UART) &&
                                 CUSTOM_FEATURE_FLAGS[ACK_POLL_BIT];
          next_cur.wake_pin    = idle_level(next_cur.poll_en, next_cur.active_high);
        end else if (PKT_PENDING && cur.poll_en && !ack_s) begin
          // a stale ack from the last packet must clear before a new request
          next_cur.state    = ST_WAIT_ACK;
          next_cur.wake_pin = cur.active_high;
        end else if (PKT_PENDING && !cur.poll_en) begin
          next_cur.state    = ST_NP_WAIT;
          next_cur.wake_pin = 1'b0;
        end
      end
      ST_WAIT_ACK: begin
        if (ack_s) begin
          next_cur.state    = ST_XFER;
          next_cur.wake_pin = ~cur.active_high;
          next_cur.xfer_go  = 1'b1;
        end
      end
      ST_XFER: begin
        if (PKT_DONE) begin
          next_cur.state = ST_IDLE;
        end
      end
      ST_NP_WAIT: begin
        // host fetches on its own; no ack is consulted here
        if (PKT_DONE) begin
          next_cur.state    = ST_IDLE;
          next_cur.wake_pin = 1'b1;
        end
      end
      default: begin
        next_cur.state    = ST_IDLE;
        next_cur.wake_pin = idle_level(cur.poll_en, cur.active_high);
      end
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cur.state       <= ST_IDLE;
      cur.active_high <= RST_ACTIVE_HIGH;
      cur.poll_en     <= RST_POLL_EN;
      cur.wake_pin    <= RST_WAKE_PIN;
      cur.xfer_go     <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from flops, except WAKE_BUSY, which is decoded from the state flops
  assign DEVICE_WAKE_REQUEST = cur.wake_pin;
  assign XFER_GO             = cur.xfer_go;
  assign WAKE_BUSY           = (cur.state != ST_IDLE);
  assign ACTIVE_HIGH         = cur.active_high;
  assign ACK_POLL_EN         = cur.poll_en;

  // polarity taken from bit 16 at setup
  chk_polarity_latch: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (MODE_SETUP && cur.state == ST_IDLE)
      |=> (cur.active_high == $past(CONFIG_FEATURE_FLAGS[ACTIVE_HIGH_BIT])))
    else $error("polarity not taken from config flag");

  // active-high request holds high while waiting
  chk_high_request: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cur.state == ST_WAIT_ACK && cur.active_high) |-> cur.wake_pin)
    else $error("active-high request not high while waiting");

  // active-high release on ack
  chk_high_release: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cur.state == ST_WAIT_ACK && cur.active_high && ack_s)
      |=> (!cur.wake_pin && cur.xfer_go && cur.state == ST_XFER))
    else $error("active-high release wrong");

  // active-low request holds low while waiting
  chk_low_request: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cur.state == ST_WAIT_ACK && !cur.active_high) |-> !cur.wake_pin)
    else $error("active-low request not low while waiting");

  // active-low release on ack
  chk_low_release: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cur.state == ST_WAIT_ACK && !cur.active_high && ack_s)
      |=> (cur.wake_pin && cur.xfer_go && cur.state == ST_XFER))
    else $error("active-low release wrong");

  // transfer only starts after a seen ack in polling
  chk_go_after_ack: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    cur.xfer_go |-> ($past(ack_s) && $past(cur.state) == ST_WAIT_ACK))
    else $error("transfer started without ack");

  // polling only ever on UART
  chk_poll_uart: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (MODE_SETUP && cur.state == ST_IDLE && HOST_LINK != LINK_UART) |=> !cur.poll_en)
    else $error("polling enabled on non-UART link");

  // non-polling request goes low and enters the wait the cycle after a pending packet
  chk_np_low: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cur.state == ST_IDLE && PKT_PENDING && !cur.poll_en && !MODE_SETUP)
      |=> (!cur.wake_pin && cur.state == ST_NP_WAIT))
    else $error("non-polling request not driven low");

  // non-polling release once packet taken
  chk_np_release: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cur.state == ST_NP_WAIT && PKT_DONE) |=> (cur.wake_pin && cur.state == ST_IDLE))
    else $error("non-polling request not released");

  // ack reaches the logic exactly two cycles late
  chk_ack_sync: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ($past(RST_N) && $past(RST_N, 2)) |-> (ack_s == $past(HOST_WAKE_ACK, 2)))
    else $error("ack synchroniser delay wrong");

  // start strobe lasts one cycle, a longer one would launch the packet twice
  chk_go_one_cycle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    cur.xfer_go |=> !cur.xfer_go)
    else $error("transfer start held longer than one cycle");

  // no transfer starts while the ack is still missing
  chk_wait_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cur.state == ST_WAIT_ACK && !ack_s)
      |=> (cur.state == ST_WAIT_ACK && !cur.xfer_go))
    else $error("left ack wait without ack");

  // request sits at its idle level during the transfer
  chk_xfer_pin: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cur.state == ST_XFER) |-> (cur.wake_pin == !cur.active_high))
    else $error("request not idle during transfer");

  // non-polling wait keeps the pin low and never strobes a transfer
  chk_np_no_go: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cur.state == ST_NP_WAIT) |-> (!cur.wake_pin && !cur.xfer_go))
    else $error("non-polling wait drove pin or strobe");

  // non-polling request holds until the host has taken the packet
  chk_np_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cur.state == ST_NP_WAIT && !PKT_DONE) |=> (cur.state == ST_NP_WAIT))
    else $error("non-polling request dropped early");

  // idle pin level follows the latched mode
  chk_idle_pin: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cur.state == ST_IDLE)
      |-> (cur.wake_pin == (cur.poll_en ? !cur.active_high : 1'b1)))
    else $error("idle request level wrong");

  // mode is frozen while a handshake is in flight
  chk_setup_refused: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (MODE_SETUP && cur.state != ST_IDLE)
      |=> (cur.active_high == $past(cur.active_high) && cur.poll_en == $past(cur.poll_en)))
    else $error("setup taken while busy");

  // on a UART link the polling enable is the custom flag bit
  chk_poll_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (MODE_SETUP && cur.state == ST_IDLE && HOST_LINK == LINK_UART)
      |=> (cur.poll_en == $past(CUSTOM_FEATURE_FLAGS[ACK_POLL_BIT])))
    else $error("polling enable not taken from custom flag");

endmodule

// >>> tb/host_wake_model.sv
// host-side model of the wake handshake pin pair
`timescale 1ns/100ps
module host_wake_model (
  // clock and reset
  input  wire logic CLK_SYS,
  input  wire logic RST_N,
  // latched mode seen by the host
  input  wire logic ACTIVE_HIGH,
  input  wire logic ENABLE,
  // handshake pins
  input  wire logic DEVICE_WAKE_REQUEST,
  output logic      HOST_WAKE_ACK
);
  logic [1:0] req_s;

  // ack follows the synchronised request, three cycles behind the request pin on purpose
  always @(posedge CLK_SYS) begin
    req_s <= {req_s[0], DEVICE_WAKE_REQUEST};
    if (!RST_N || !ENABLE) begin
      HOST_WAKE_ACK <= 1'b0;
    end else if (req_s[1] == ACTIVE_HIGH) begin
      HOST_WAKE_ACK <= 1'b1;
    end else begin
      HOST_WAKE_ACK <= 1'b0;
    end
  end
endmodule

// >>> tb/test_wake_on_wireless_handshake.sv
// self-checking bench for the wake handshake against a host model
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module test_wake_on_wireless_handshake;
  import wake_pkg::*;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               mode_setup = 1'b0;
  logic [FLAGS_W-1:0] cfg_flags = '0;
  logic [FLAGS_W-1:0] cust_flags = '0;
  host_link_e         link = LINK_UART;
  logic               pkt_pending = 1'b0;
  logic               pkt_done = 1'b0;
  logic               xfer_go, wake_busy, active_high, ack_poll_en, wake_req, wake_ack;
  int                 err_count = 0;
  int                 n_checks = 0;
  int                 cycles = 0;

  always #25 clk_sys = ~clk_sys;

  wake_on_wireless_handshake u_wake_on_wireless_handshake (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .MODE_SETUP(mode_setup),
    .CONFIG_FEATURE_FLAGS(cfg_flags), .CUSTOM_FEATURE_FLAGS(cust_flags),
    .HOST_LINK(link), .PKT_PENDING(pkt_pending), .PKT_DONE(pkt_done),
    .XFER_GO(xfer_go), .WAKE_BUSY(wake_busy), .ACTIVE_HIGH(active_high),
    .ACK_POLL_EN(ack_poll_en), .DEVICE_WAKE_REQUEST(wake_req), .HOST_WAKE_ACK(wake_ack));
  host_wake_model u_host_wake_model (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .ACTIVE_HIGH(active_high), .ENABLE(ack_poll_en),
    .DEVICE_WAKE_REQUEST(wake_req), .HOST_WAKE_ACK(wake_ack));

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // every output at its rest value just after a reset
  task automatic check_rest;
    `CHK(wake_req, RST_WAKE_PIN)
    `CHK(active_high, RST_ACTIVE_HIGH)
    `CHK(ack_poll_en, RST_POLL_EN)
    `CHK(wake_busy, 1'b0)
    `CHK(xfer_go, 1'b0)
  endtask

  // reset in the middle of a non-polling request drops the request
  task automatic mid_reset;
    @(posedge clk_sys);
    pkt_pending <= 1'b1;
    @(posedge clk_sys);
    pkt_pending <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check_rest();
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic setup(input logic ah, input logic poll, input host_link_e lk);
    @(posedge clk_sys);
    mode_setup <= 1'b1;
    cfg_flags <= FLAGS_W'(ah) << ACTIVE_HIGH_BIT;
    cust_flags <= FLAGS_W'(poll) << ACK_POLL_BIT;
    link <= lk;
    @(posedge clk_sys);
    mode_setup <= 1'b0;
    @(posedge clk_sys) #1;
    `CHK(active_high, ah)
    `CHK(ack_poll_en, poll && lk == LINK_UART)
    // host sees the old pin level against the new polarity and may ack once
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic poll_xfer(input logic ah);
    int n;
    n = 0;
    `CHK(wake_req, ~ah)
    @(posedge clk_sys);
    pkt_pending <= 1'b1;
    @(posedge clk_sys);
    pkt_pending <= 1'b0;
    @(posedge clk_sys) #1;
    `CHK(wake_req, ah)
    while (xfer_go !== 1'b1 && n < 40) begin
      `CHK(wake_req, ah)
      @(posedge clk_sys) #1;
      n++;
    end
    `CHK(xfer_go, 1'b1)
    `CHK(wake_ack, 1'b1)
    `CHK(wake_req, ~ah)
    @(posedge clk_sys);
    pkt_done <= 1'b1;
    @(posedge clk_sys);
    pkt_done <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK(wake_busy, 1'b0)
  endtask

  // no ack is ever given here, so progress proves the wait is skipped
  task automatic np_xfer;
    @(posedge clk_sys);
    pkt_pending <= 1'b1;
    @(posedge clk_sys);
    pkt_pending <= 1'b0;
    repeat (4) begin
      @(posedge clk_sys) #1;
      `CHK(wake_req, 1'b0)
      `CHK(xfer_go, 1'b0)
    end
    // a setup while busy must be ignored
    @(posedge clk_sys);
    mode_setup <= 1'b1;
    cfg_flags <= '0;
    @(posedge clk_sys);
    mode_setup <= 1'b0;
    pkt_done <= 1'b1;
    @(posedge clk_sys);
    pkt_done <= 1'b0;
    #1;
    `CHK(wake_req, 1'b1)
    `CHK(wake_busy, 1'b0)
    `CHK(active_high, 1'b1)
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check_rest();
    setup(1'b1, 1'b1, LINK_UART);
    poll_xfer(1'b1);
    setup(1'b0, 1'b1, LINK_UART);
    poll_xfer(1'b0);
    setup(1'b1, 1'b0, LINK_UART);
    np_xfer();
    for (int i = 1; i <= 4; i++) begin
      setup(1'b1, 1'b1, host_link_e'(i));
      np_xfer();
    end
    mid_reset();
    give_verdict();
  end
endmodule
